// file: hdl/gltsq_pkg.sv
// package of the generator-set load transfer sequencer
// assumes one 10 MHz core clock; all time settings are counted in 0.1 s ticks

package gltsq_pkg;
	// =============================================================
	// widths and clock
	localparam int TW = 20;
	localparam int PW = 16;
	localparam int CLK_NS = 100;
	localparam int TICK_NS = 100_000_000;
	localparam int TICK_CYCLES_DFLT = TICK_NS / CLK_NS;
	localparam int TICKS_PER_S = 1_000_000_000 / TICK_NS;

	// =============================================================
	// factory settings, in their own unit and in ticks
	localparam int OVL_TIME_DFLT_S = 3;
	localparam int MAINS_WAIT_DFLT_S = 30;
	localparam int CON_TIME_DFLT_MS = 500;
	localparam int PULSE_DFLT_MS = 500;
	localparam int BRK_FAIL_DFLT_MS = 2000;
	localparam int OVL_TIME_DFLT = OVL_TIME_DFLT_S * TICKS_PER_S;
	localparam int MAINS_WAIT_DFLT = MAINS_WAIT_DFLT_S * TICKS_PER_S;
	localparam int CON_TIME_DFLT = CON_TIME_DFLT_MS * TICKS_PER_S / 1000;
	localparam int PULSE_DFLT = PULSE_DFLT_MS * TICKS_PER_S / 1000;
	localparam int BRK_FAIL_DFLT = BRK_FAIL_DFLT_MS * TICKS_PER_S / 1000;

	// =============================================================
	// load steps and connection topologies
	localparam logic [2:0] NSTEPS = 3'h5;
	localparam logic [2:0] STEPS_RST = NSTEPS;
	localparam logic [2:0] TOPO_2PH_L12 = 3'h0;
	localparam logic [2:0] TOPO_2PH_L13 = 3'h1;
	localparam logic [2:0] TOPO_3PH_3W = 3'h2;
	localparam logic [2:0] TOPO_2CT_L12 = 3'h3;
	localparam logic [2:0] TOPO_2CT_L13 = 3'h4;
	localparam logic [2:0] TOPO_STAR4 = 3'h5;
	localparam logic [2:0] TOPO_DELTA4 = 3'h6;
	localparam logic [2:0] TOPO_1PH = 3'h7;
	localparam logic [2:0] TOPO_DFLT = TOPO_STAR4;

	// =============================================================
	// state types
	typedef enum logic [1:0] {TR_TO_MAINS, TR_MAINS, TR_TO_GEN, TR_GEN} gltsq_tr_t;
	typedef enum logic [2:0] {BK_OPEN, BK_COIL, BK_CLOSE, BK_SHUT, BK_OPENP} gltsq_bk_t;
	typedef struct packed {
		gltsq_bk_t ph;
		logic [TW-1:0] cnt;
		logic [TW-1:0] fcnt;
		logic coil;
		logic close_r;
		logic open_r;
		logic fault;
	} gltsq_brk_t;
	typedef struct packed {
		logic [TW-1:0] tick_cnt;
		logic tick;
		logic [4:0] s1;
		logic [4:0] s2;
		gltsq_tr_t tr;
		logic [TW-1:0] tr_cnt;
		logic mcon;
		logic gcon;
		logic [TW-1:0] ovl_cnt;
		logic ovl_alm;
		logic shed;
		logic exc_warn;
		logic mph_warn;
		logic gph_alm;
		logic [TW-1:0] since_add;
		logic [TW-1:0] since_sub;
		logic [TW-1:0] subq;
		logic [TW-1:0] addq;
		logic [2:0] steps;
		logic add_p;
		logic sub_p;
		gltsq_brk_t mb;
		gltsq_brk_t gb;
		logic brk_sd;
		logic brk_ld;
		logic [1:0] m_phases;
		logic [1:0] g_phases;
	} gltsq_state_t;
endpackage : gltsq_pkg

// file: hdl/gltsq_top.sv
// generator-set load transfer sequencer: overload, shedding, five-step load, transfer
// assumes pins arrive asynchronous; power and settings come from same-clock logic
//
// Summary of operation
// - overload loaddump on generator; zero limit disables
// - overload declared after fail time persists
// - shedding relay on above high, off below low
// - load-add pulses spaced by load add delay
// - no add pulse until subtract-add delay passes
// - mains healthy for wait time, then drop generator
// - topology codes 0..7 select phase arrangement
// - generator off, wait, then mains contactor on
// - mains off, wait, then generator contactor on
// - hold coil energised for coil time before closing
// - close relay pulsed for close pulse time
// - open relay pulsed for open pulse time
// - feedback not following within fail time: fault
// - alarm level picks shutdown or loaddump class
// - mains phase fault warns and drops mains contactor
// - generator phase fault raises loaddump alarm
// - power above subtract level for start delay
// - subtract operations spaced by subtract wait
// - power below add level for start delay
// - add operations spaced by add wait
// - power above excess limit gives warning
`timescale 1ns/1ps

module gltsq_top import gltsq_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYCLES_DFLT
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// measurements and requests
	input wire logic [PW-1:0] gen_power_kw,
	input wire logic gen_ready,
	input wire logic alarm_clr,
	// asynchronous pins
	input wire logic mains_ok_pin,
	input wire logic mains_phase_bad_pin,
	input wire logic gen_phase_bad_pin,
	input wire logic mains_brk_fb_pin,
	input wire logic gen_brk_fb_pin,
	// power settings
	input wire logic [PW-1:0] ovl_limit,
	input wire logic [PW-1:0] shed_lo,
	input wire logic [PW-1:0] shed_hi,
	input wire logic [PW-1:0] sub_level,
	input wire logic [PW-1:0] add_level,
	input wire logic [PW-1:0] excess_limit,
	// time settings in ticks
	input wire logic [TW-1:0] ovl_time,
	input wire logic [TW-1:0] add_delay,
	input wire logic [TW-1:0] sub_add_delay,
	input wire logic [TW-1:0] sub_start,
	input wire logic [TW-1:0] sub_wait,
	input wire logic [TW-1:0] add_start,
	input wire logic [TW-1:0] add_wait,
	input wire logic [TW-1:0] mains_wait,
	input wire logic [TW-1:0] mains_con_time,
	input wire logic [TW-1:0] gen_con_time,
	// breaker settings, index 0 mains, 1 generator
	input wire logic [1:0][TW-1:0] brk_coil_time,
	input wire logic [1:0][TW-1:0] brk_close_time,
	input wire logic [1:0][TW-1:0] brk_open_time,
	input wire logic [1:0][TW-1:0] brk_fail_time,
	input wire logic [1:0] brk_fb_en,
	input wire logic [1:0] brk_alarm_lvl,
	// phase and topology settings
	input wire logic m_phase_chk,
	input wire logic g_phase_chk,
	input wire logic [2:0] mains_topo_sel,
	input wire logic [2:0] gen_topo_sel,
	// contactor and breaker drives
	output logic mains_contactor,
	output logic gen_contactor,
	output logic [1:0] breaker_hold_coil,
	output logic [1:0] breaker_close_relay,
	output logic [1:0] breaker_open_relay,
	// load management
	output logic shed_relay,
	output logic load_add_pulse,
	output logic load_sub_pulse,
	output logic [2:0] load_steps,
	// alarms and status
	output logic overload_loaddump,
	output logic excess_power_warn,
	output logic mains_phase_warn,
	output logic gen_phase_loaddump,
	output logic breaker_shutdown,
	output logic breaker_loaddump,
	output logic [1:0] mains_phases,
	output logic [1:0] gen_phases
);
	// =============================================================
	// helpers
	gltsq_state_t q;
	gltsq_state_t d;
	logic tk;
	logic mgood;
	logic gok;
	logic c_ovl;
	logic c_sub;
	logic c_add;
	logic ok_add;

	// saturating qualification count, cleared when its condition drops
	function automatic logic [TW-1:0] inc(input logic en, input logic t, input logic [TW-1:0] c);
		return !en ? '0 : (t && c != '1) ? c + 1'b1 : c;
	endfunction : inc

	// phase count of a topology code
	function automatic logic [1:0] phases(input logic [2:0] code);
		case (code)
			TOPO_2PH_L12, TOPO_2PH_L13: return 2'h2;
			TOPO_1PH: return 2'h1;
			default: return 2'h3;
		endcase
	endfunction : phases

	// one motorized breaker: coil, close pulse, open pulse, feedback watch
	function automatic gltsq_brk_t brk_step(input gltsq_brk_t b, input logic cmd,
		input logic fb, input int i);
		gltsq_brk_t n;
		logic miss;
		n = b;
		n.cnt = (tk && b.cnt != '1) ? b.cnt + 1'b1 : b.cnt;
		case (b.ph)
			BK_OPEN: if (cmd) begin
				n.ph = BK_COIL;
				n.cnt = '0;
				n.coil = 1'b1;
			end
			BK_COIL: if (!cmd) begin
				n.ph = BK_OPEN;
				n.coil = 1'b0;
			end else if (b.cnt >= brk_coil_time[i]) begin
				n.ph = BK_CLOSE;
				n.cnt = '0;
				n.close_r = 1'b1;
			end
			BK_CLOSE: if (b.cnt >= brk_close_time[i]) begin
				n.ph = BK_SHUT;
				n.close_r = 1'b0;
			end
			BK_SHUT: if (!cmd) begin
				n.ph = BK_OPENP;
				n.cnt = '0;
				n.coil = 1'b0;
				n.open_r = 1'b1;
			end
			BK_OPENP: if (b.cnt >= brk_open_time[i]) begin
				n.ph = BK_OPEN;
				n.open_r = 1'b0;
			end
			default: n.ph = BK_OPEN;
		endcase
		miss = brk_fb_en[i] && (fb != cmd);
		n.fcnt = inc(miss, tk, b.fcnt);
		n.fault = (miss && b.fcnt >= brk_fail_time[i]) || (b.fault && !alarm_clr);
		return n;
	endfunction : brk_step

	// =============================================================
	// next state
	always_comb begin
		d = q;
		d.add_p = 1'b0;
		d.sub_p = 1'b0;
		// common 0.1 s tick
		d.tick = (q.tick_cnt == TW'(TICK_CYCLES - 1));
		d.tick_cnt = d.tick ? '0 : q.tick_cnt + 1'b1;
		tk = q.tick;
		// pin synchronisers
		d.s1 = {gen_brk_fb_pin, mains_brk_fb_pin, gen_phase_bad_pin, mains_phase_bad_pin,
			mains_ok_pin};
		d.s2 = q.s1;
		mgood = q.s2[0] && !(m_phase_chk && q.s2[1]);
		gok = gen_ready && !q.ovl_alm && !q.gph_alm && !q.brk_ld && !q.brk_sd;
		// overload supervision
		c_ovl = q.gcon && ovl_limit != '0 && gen_power_kw > ovl_limit;
		d.ovl_cnt = inc(c_ovl, tk, q.ovl_cnt);
		d.ovl_alm = (c_ovl && q.ovl_cnt >= ovl_time) || (q.ovl_alm && !alarm_clr);
		// single shedding relay with hysteresis
		if (gen_power_kw > shed_hi) begin
			d.shed = 1'b1;
		end else if (gen_power_kw < shed_lo) begin
			d.shed = 1'b0;
		end
		// warnings and phase alarms
		d.exc_warn = excess_limit != '0 && gen_power_kw > excess_limit;
		d.mph_warn = m_phase_chk && q.s2[1];
		d.gph_alm = (g_phase_chk && q.s2[2]) || (q.gph_alm && !alarm_clr);
		// five-step load management
		d.since_add = inc(1'b1, tk, q.since_add);
		d.since_sub = inc(1'b1, tk, q.since_sub);
		c_sub = q.gcon && sub_level != '0 && gen_power_kw > sub_level && q.steps != '0;
		c_add = q.gcon && gen_power_kw < add_level && q.steps < NSTEPS;
		d.subq = inc(c_sub, tk, q.subq);
		d.addq = inc(c_add, tk, q.addq);
		ok_add = q.since_add >= add_delay && q.since_add >= add_wait
			&& q.since_sub >= sub_add_delay;
		if (c_sub && q.subq >= sub_start && q.since_sub >= sub_wait) begin
			d.steps = q.steps - 1'b1;
			d.sub_p = 1'b1;
			d.since_sub = '0;
			d.subq = '0;
		end else if (c_add && q.addq >= add_start && ok_add) begin
			d.steps = q.steps + 1'b1;
			d.add_p = 1'b1;
			d.since_add = '0;
			d.addq = '0;
		end
		// topology decode
		d.m_phases = phases(mains_topo_sel);
		d.g_phases = phases(gen_topo_sel);
		// transfer sequencer
		d.tr_cnt = inc(1'b1, tk, q.tr_cnt);
		case (q.tr)
			TR_MAINS: if (!mgood) begin
				d.mcon = 1'b0;
				d.tr = TR_TO_GEN;
				d.tr_cnt = '0;
			end
			TR_TO_GEN: if (mgood) begin
				d.tr = TR_TO_MAINS;
				d.tr_cnt = '0;
			end else if (gok && q.tr_cnt >= gen_con_time) begin
				d.gcon = 1'b1;
				d.tr = TR_GEN;
			end
			TR_GEN: begin
				d.tr_cnt = inc(mgood, tk, q.tr_cnt);
				if (!gok || (mgood && q.tr_cnt >= mains_wait)) begin
					d.gcon = 1'b0;
					d.tr = TR_TO_MAINS;
					d.tr_cnt = '0;
				end
			end
			TR_TO_MAINS: if (!mgood) begin
				d.tr = TR_TO_GEN;
				d.tr_cnt = '0;
			end else if (q.tr_cnt >= mains_con_time) begin
				d.mcon = 1'b1;
				d.tr = TR_MAINS;
			end
			default: d.tr = TR_TO_MAINS;
		endcase
		// breakers follow the contactor commands
		d.mb = brk_step(q.mb, q.mcon, q.s2[3], 0);
		d.gb = brk_step(q.gb, q.gcon, q.s2[4], 1);
		d.brk_sd = (d.mb.fault && !brk_alarm_lvl[0]) || (d.gb.fault && !brk_alarm_lvl[1]);
		d.brk_ld = (d.mb.fault && brk_alarm_lvl[0]) || (d.gb.fault && brk_alarm_lvl[1]);
	end

	// state register, synchronous reset
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			q <= '0;
			q.since_add <= '1;
			q.since_sub <= '1;
			q.steps <= STEPS_RST;
			q.m_phases <= 2'h3;
			q.g_phases <= 2'h3;
		end else begin
			q <= d;
		end
	end

	// =============================================================
	// outputs, all straight from the state register
	assign mains_contactor = q.mcon;
	assign gen_contactor = q.gcon;
	assign breaker_hold_coil = {q.gb.coil, q.mb.coil};
	assign breaker_close_relay = {q.gb.close_r, q.mb.close_r};
	assign breaker_open_relay = {q.gb.open_r, q.mb.open_r};
	assign shed_relay = q.shed;
	assign load_add_pulse = q.add_p;
	assign load_sub_pulse = q.sub_p;
	assign load_steps = q.steps;
	assign overload_loaddump = q.ovl_alm;
	assign excess_power_warn = q.exc_warn;
	assign mains_phase_warn = q.mph_warn;
	assign gen_phase_loaddump = q.gph_alm;
	assign breaker_shutdown = q.brk_sd;
	assign breaker_loaddump = q.brk_ld;
	assign mains_phases = q.m_phases;
	assign gen_phases = q.g_phases;

	// =============================================================
	// assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	a_ovl_disabled: assert property ((ovl_limit == '0 && !q.ovl_alm) |=> !q.ovl_alm)
		else $error("overload alarm with supervision disabled");
	a_ovl_qualify: assert property ($rose(q.ovl_alm) |-> $past(q.ovl_cnt) >= $past(ovl_time))
		else $error("overload alarm before fail time");
	a_shed_on: assert property ((gen_power_kw > shed_hi) |=> q.shed)
		else $error("shedding relay not activated");
	a_add_spacing: assert property (q.add_p |-> $past(q.since_add) >= $past(add_delay))
		else $error("load add pulses too close");
	a_sub_to_add: assert property (q.add_p |-> $past(q.since_sub) >= $past(sub_add_delay))
		else $error("load add too soon after subtract");
	a_mains_wait: assert property (($past(q.tr) == TR_GEN && q.tr == TR_TO_MAINS && $past(gok))
		|-> $past(q.tr_cnt) >= $past(mains_wait))
		else $error("generator dropped before mains wait");
	a_mains_gap: assert property ($rose(q.mcon) |-> $past(q.tr_cnt) >= $past(mains_con_time))
		else $error("mains contactor closed too soon");
	a_gen_gap: assert property ($rose(q.gcon) |-> !q.mcon && $past(q.tr_cnt) >= $past(gen_con_time))
		else $error("generator contactor closed too soon");
	a_coil_first: assert property ($rose(q.mb.close_r)
		|-> q.mb.coil && $past(q.mb.cnt) >= $past(brk_coil_time[0]))
		else $error("close relay before coil time");
	a_close_len: assert property ($fell(q.gb.close_r) |-> $past(q.gb.cnt) >= $past(brk_close_time[1]))
		else $error("close pulse too short");
	a_brk_class: assert property ((q.mb.fault && !$past(brk_alarm_lvl[0])) |-> q.brk_sd)
		else $error("breaker fault class wrong");
	a_mains_phase: assert property ((m_phase_chk && q.s2[1]) |=> !q.mcon && q.mph_warn)
		else $error("mains phase fault not handled");
	a_gen_phase: assert property ((g_phase_chk && q.s2[2]) |=> q.gph_alm)
		else $error("generator phase alarm missing");

	c_transfer: cover property ($rose(q.gcon) ##[1:1000] $rose(q.mcon));
	c_subtract: cover property (q.sub_p);
	c_brk_fault: cover property ($rose(q.mb.fault));
endmodule : gltsq_top

// file: dv/gltsq_brk_model.sv
// breaker and contactor far side: auxiliary feedback follows the drive
// assumes the bench's core clock; stuck freezes a feedback contact
`timescale 1ns/1ps

module gltsq_brk_model #(
	parameter int LAG = 15
) (
	// clock
	input wire logic core_clk,
	// drives from the sequencer, [0] mains [1] generator
	input wire logic [1:0] cmd,
	input wire logic [1:0] stuck,
	// feedback contacts, 1 = closed
	output logic [1:0] fb
);
	int cnt [2];
	logic [1:0] fb_q = 2'h0;

	// =============================================================
	// mechanism travel time, shorter than the fail time
	assign fb = fb_q;
	always @(posedge core_clk) begin
		for (int i = 0; i < 2; i++) begin
			if (stuck[i] || fb_q[i] == cmd[i]) begin
				cnt[i] <= 0;
			end else if (cnt[i] >= LAG) begin
				fb_q[i] <= cmd[i];
				cnt[i] <= 0;
			end else begin
				cnt[i] <= cnt[i] + 1;
			end
		end
	end
endmodule : gltsq_brk_model

// file: dv/tb.sv
// bench for the load transfer sequencer, one tick every 10 clocks
// assumes gltsq_pkg and the breaker model are compiled first
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
	$display("wrong value at %0t: got %0h exp %0h", $time, (a), (e)); end end

module tb import gltsq_pkg::*; ;
	logic core_clk, resetn, gen_ready, alarm_clr, mains_ok_pin, mains_phase_bad_pin;
	logic gen_phase_bad_pin, m_phase_chk, g_phase_chk;
	logic [PW-1:0] gen_power_kw, ovl_limit, shed_lo, shed_hi, sub_level, add_level, excess_limit;
	logic [TW-1:0] ovl_time, add_delay, sub_add_delay, sub_start, sub_wait, add_start;
	logic [TW-1:0] add_wait, mains_wait, mains_con_time, gen_con_time;
	logic [1:0][TW-1:0] brk_coil_time, brk_close_time, brk_open_time, brk_fail_time;
	logic [1:0] brk_fb_en, brk_alarm_lvl, fb, stuck, breaker_hold_coil, breaker_close_relay;
	logic [1:0] breaker_open_relay, mains_phases, gen_phases;
	logic [2:0] mains_topo_sel, gen_topo_sel, load_steps;
	logic mains_contactor, gen_contactor, shed_relay, load_add_pulse, load_sub_pulse;
	logic overload_loaddump, excess_power_warn, mains_phase_warn, gen_phase_loaddump;
	logic breaker_shutdown, breaker_loaddump;
	int err_count = 0, comparisons = 0, cyc = 0, t0, i;

	// =============================================================
	// design and far side
	gltsq_top #(.TICK_CYCLES(10)) u_gltsq_top (.core_clk, .resetn, .gen_power_kw, .gen_ready,
		.alarm_clr, .mains_ok_pin, .mains_phase_bad_pin, .gen_phase_bad_pin,
		.mains_brk_fb_pin(fb[0]), .gen_brk_fb_pin(fb[1]), .ovl_limit, .shed_lo, .shed_hi,
		.sub_level, .add_level, .excess_limit, .ovl_time, .add_delay, .sub_add_delay,
		.sub_start, .sub_wait, .add_start, .add_wait, .mains_wait, .mains_con_time,
		.gen_con_time, .brk_coil_time, .brk_close_time, .brk_open_time, .brk_fail_time,
		.brk_fb_en, .brk_alarm_lvl, .m_phase_chk, .g_phase_chk, .mains_topo_sel, .gen_topo_sel,
		.mains_contactor, .gen_contactor, .breaker_hold_coil, .breaker_close_relay,
		.breaker_open_relay, .shed_relay, .load_add_pulse, .load_sub_pulse, .load_steps,
		.overload_loaddump, .excess_power_warn, .mains_phase_warn, .gen_phase_loaddump,
		.breaker_shutdown, .breaker_loaddump, .mains_phases, .gen_phases);
	gltsq_brk_model u_gltsq_brk_model (.core_clk, .cmd({gen_contactor, mains_contactor}),
		.stuck, .fb);

	// clock and cycle count
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	always @(posedge core_clk) cyc <= cyc + 1;

	// output picked for a bounded wait
	function automatic logic pick(input int s);
		case (s)
			0: return mains_contactor;
			1: return gen_contactor;
			2: return breaker_hold_coil[0];
			3: return breaker_close_relay[0];
			4: return breaker_open_relay[0];
			5: return overload_loaddump;
			6: return load_sub_pulse;
			7: return load_add_pulse;
			8: return breaker_shutdown;
			10: return breaker_hold_coil[1];
			11: return breaker_close_relay[1];
			12: return breaker_open_relay[1];
			default: return gen_phase_loaddump;
		endcase
	endfunction : pick

	task tally_and_finish;
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	task wt(input int s, input logic v);
		int n;
		n = 0;
		#1;
		while (pick(s) !== v) begin
			@(posedge core_clk);
			#1;
			n++;
			if (n > 2000) begin
				err_count++;
				$display("wrong value at %0t: got %0h exp %0h", $time, pick(s), v);
				tally_and_finish();
			end
		end
	endtask : wt

	// elapsed time since st matches t ticks, tick phase allowed for
	task near(input int st, input int t);
		`CHK((cyc - st >= t * 10 - 10) && (cyc - st <= t * 10 + 8), 1'b1)
	endtask : near

	// set power, then look at shedding relay and excess warning
	task pw(input logic [PW-1:0] p, input logic s, input logic e);
		@(posedge core_clk) gen_power_kw <= p;
		repeat (4) @(posedge core_clk);
		#1;
		`CHK(shed_relay, s)
		`CHK(excess_power_warn, e)
	endtask : pw

	// =============================================================
	// main sequence
	initial begin
		{resetn, gen_ready, alarm_clr, mains_ok_pin, mains_phase_bad_pin} = 5'h00;
		{gen_phase_bad_pin, m_phase_chk, g_phase_chk, stuck} = 5'h00;
		{gen_power_kw, ovl_limit} = 32'h0000_0000;
		{shed_lo, shed_hi, sub_level} = {16'h0064, 16'h00c8, 16'h0190};
		{add_level, excess_limit} = {16'h0064, 16'h012c};
		{ovl_time, add_delay, sub_add_delay} = {20'h0_0004, 20'h0_0005, 20'h0_0008};
		{sub_start, sub_wait, add_start} = {20'h0_0003, 20'h0_0006, 20'h0_0002};
		{add_wait, mains_wait} = {20'h0_0002, 20'h0_0006};
		{mains_con_time, gen_con_time} = {20'h0_0005, 20'h0_0004};
		brk_coil_time = {2{20'h0_0002}};
		brk_close_time = {2{20'h0_0003}};
		brk_open_time = {2{20'h0_0002}};
		brk_fail_time = {2{20'h0_0004}};
		{brk_fb_en, brk_alarm_lvl, mains_topo_sel, gen_topo_sel} = {2'h3, 2'h2, 3'h5, 3'h5};
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		`CHK(load_steps, 3'h5)
		for (i = 0; i < 8; i++) begin
			@(posedge core_clk) {mains_topo_sel, gen_topo_sel} <= {i[2:0], 3'h7 - i[2:0]};
			repeat (2) @(posedge core_clk);
			#1;
			`CHK(mains_phases, (i < 2) ? 2'h2 : (i == 7) ? 2'h1 : 2'h3)
			`CHK(gen_phases, (i > 5) ? 2'h2 : (i == 0) ? 2'h1 : 2'h3)
		end
		// mains breaker closing sequence
		@(posedge core_clk) mains_ok_pin <= 1'b1;
		wt(0, 1'b1);
		wt(2, 1'b1);
		t0 = cyc;
		wt(3, 1'b1);
		near(t0, 2);
		t0 = cyc;
		wt(3, 1'b0);
		near(t0, 3);
		// mains lost: open pulse, gap, generator on
		@(posedge core_clk) {gen_ready, mains_ok_pin} <= 2'h2;
		wt(0, 1'b0);
		t0 = cyc;
		wt(4, 1'b1);
		i = cyc;
		wt(4, 1'b0);
		near(i, 2);
		wt(1, 1'b1);
		near(t0, 4);
		// generator breaker: hold coil, then close relay after coil time
		wt(10, 1'b1);
		t0 = cyc;
		wt(11, 1'b1);
		near(t0, 2);
		// shedding with hysteresis, excess warning, overload disabled at zero
		pw(16'h00fa, 1'b1, 1'b0);
		pw(16'h015e, 1'b1, 1'b1);
		pw(16'h0096, 1'b1, 1'b0);
		pw(16'h0032, 1'b0, 1'b0);
		pw(16'h015e, 1'b1, 1'b1);
		`CHK(overload_loaddump, 1'b0)
		// subtract qualification restarts on a dip
		pw(16'h01c2, 1'b1, 1'b1);
		pw(16'h015e, 1'b1, 1'b1);
		@(posedge core_clk) gen_power_kw <= 16'h01c2;
		#1 t0 = cyc;
		wt(6, 1'b1);
		near(t0, 3);
		t0 = cyc;
		wt(6, 1'b0);
		wt(6, 1'b1);
		near(t0, 6);
		t0 = cyc;
		@(posedge core_clk) gen_power_kw <= 16'h0032;
		wt(7, 1'b1);
		near(t0, 8);
		#100;
		`CHK(load_steps, 3'h4)
		t0 = cyc;
		wt(7, 1'b0);
		wt(7, 1'b1);
		near(t0, 5);
		repeat (80) @(posedge core_clk);
		#1;
		`CHK(load_steps, 3'h5)
		// overload needs uninterrupted persistence
		@(posedge core_clk) {ovl_limit, gen_power_kw} <= {16'h01f4, 16'h0258};
		repeat (25) @(posedge core_clk);
		gen_power_kw <= 16'h0032;
		repeat (3) @(posedge core_clk);
		gen_power_kw <= 16'h0258;
		#1 t0 = cyc;
		wt(5, 1'b1);
		near(t0, 4);
		wt(1, 1'b0);
		wt(12, 1'b1);
		@(posedge core_clk) {alarm_clr, gen_power_kw} <= {1'b1, 16'h0032};
		@(posedge core_clk) alarm_clr <= 1'b0;
		wt(5, 1'b0);
		wt(1, 1'b1);
		// mains return: a blip does not count
		@(posedge core_clk) mains_ok_pin <= 1'b1;
		repeat (20) @(posedge core_clk);
		mains_ok_pin <= 1'b0;
		repeat (5) @(posedge core_clk);
		mains_ok_pin <= 1'b1;
		#1 t0 = cyc;
		wt(1, 1'b0);
		near(t0, 6);
		t0 = cyc;
		wt(0, 1'b1);
		near(t0, 5);
		// let the mains feedback close before it is frozen
		repeat (20) @(posedge core_clk);
		// phase order ignored, then checked; stuck feedback faults
		@(posedge core_clk) {mains_phase_bad_pin, gen_phase_bad_pin, stuck} <= 4'hd;
		repeat (8) @(posedge core_clk);
		#1;
		`CHK({mains_phase_warn, gen_phase_loaddump, mains_contactor}, 3'h1)
		`CHK({breaker_shutdown, breaker_loaddump}, 2'h0)
		@(posedge core_clk) {m_phase_chk, g_phase_chk} <= 2'h3;
		wt(0, 1'b0);
		t0 = cyc;
		`CHK(mains_phase_warn, 1'b1)
		wt(8, 1'b1);
		near(t0, 4);
		`CHK(breaker_loaddump, 1'b0)
		wt(9, 1'b1);
		tally_and_finish();
	end
endmodule : tb
